// *** core/atd_decoder.sv ***
// Decoder and execute logic for four accumulator load instructions.
`timescale 1ns/100ps
// Summary of operation
// - Opcode 1001011001 copies wake control one into accumulator, one cycle, carry kept.
// - Opcode 1001011010 copies wake control two into accumulator, one cycle, carry kept.
// - Conversion-low load puts conversion bits one, zero into accumulator bits three, two.
// - Conversion-low load clears accumulator bits one and zero.
// - Opcode 101100jjjj is RAM load with immediate, one cycle, carry kept, no skip.
// - RAM load fills accumulator from RAM word at the data pointer.
// - RAM load replaces file selector with its XOR against the immediate.
module atd_decoder
    import atd_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    input  wire logic               insn_valid_i,
    input  wire logic [INSN_W-1:0]  insn_i,
    input  wire logic [ACC_W-1:0]   wake_ctrl_one_i,
    input  wire logic [ACC_W-1:0]   wake_ctrl_two_i,
    input  wire logic [CONV_W-1:0]  conv_result_i,
    input  wire logic [PTR_W-1:0]   data_pointer_i,
    input  wire logic               ram_wr_en_i,
    input  wire logic [PTR_W-1:0]   ram_wr_addr_i,
    input  wire logic [ACC_W-1:0]   ram_wr_data_i,
    input  wire logic               carry_flag_i,
    output logic      [ACC_W-1:0]   acc_o,
    output logic      [FILE_W-1:0]  file_sel_o,
    output logic                    carry_flag_o,
    output logic                    skip_o,
    output logic                    done_o
);
    ////////////////////////////////////////////////////////////////////////////////
    atd_op_e           op_nxt;
    atd_op_e           op_r;
    logic [ACC_W-1:0]  ram_word;
    logic [ACC_W-1:0]  acc_r;
    logic [ACC_W-1:0]  acc_nxt;
    logic [FILE_W-1:0] file_r;
    logic [FILE_W-1:0] file_nxt;
    logic [IMM_W-1:0]  imm;
    logic              carry_r;
    logic              done_r;

    assign imm = insn_i[IMM_W-1:0];

    // Opcode decode.
    always_comb begin
        op_nxt = ATD_OP_NONE;
        if (insn_valid_i) begin
            if (insn_i == OP_WAKE_ONE) begin
                op_nxt = ATD_OP_WAKE_ONE;
            end else if (insn_i == OP_WAKE_TWO) begin
                op_nxt = ATD_OP_WAKE_TWO;
            end else if (insn_i == OP_CONV_LOW) begin
                op_nxt = ATD_OP_CONV_LOW;
            end else if (insn_i[INSN_W-1:IMM_W] == OP_RAM_XOR_PFX) begin
                op_nxt = ATD_OP_RAM_XOR;
            end
        end
    end

    // RAM read is registered, so the accumulator update lands one edge later.
    atd_ram u_ram (
        .clk_i     (clk_i),
        .wr_en_i   (ram_wr_en_i),
        .wr_addr_i (ram_wr_addr_i),
        .wr_data_i (ram_wr_data_i),
        .rd_addr_i (data_pointer_i),
        .rd_data_o (ram_word)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulator and file selector values computed in the same cycle as decode.
    always_comb begin
        acc_nxt  = acc_r;
        file_nxt = file_r;
        case (op_nxt)
            ATD_OP_WAKE_ONE: begin
                acc_nxt = wake_ctrl_one_i;
            end
            ATD_OP_WAKE_TWO: begin
                acc_nxt = wake_ctrl_two_i;
            end
            ATD_OP_CONV_LOW: begin
                acc_nxt = {conv_result_i[1:0], CONV_LOW_FILL};
            end
            ATD_OP_RAM_XOR: begin
                file_nxt = file_r ^ imm;
            end
            default: begin
                acc_nxt = acc_r;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            op_r <= ATD_OP_NONE;
        end else begin
            op_r <= op_nxt;
        end
    end

    // Accumulator register; RAM data arrive on the registered read port.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            acc_r <= ACC_RESET;
        end else if (op_r == ATD_OP_RAM_XOR) begin
            acc_r <= (op_nxt == ATD_OP_NONE) ? ram_word : acc_nxt;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            file_r <= FILE_RESET;
        end else begin
            file_r <= file_nxt;
        end
    end

    // Carry passes through untouched by every decoded instruction.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            carry_r <= 1'b0;
        end else begin
            carry_r <= carry_flag_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (op_nxt != ATD_OP_NONE);
        end
    end

    // Accumulator shows RAM data as soon as the read port delivers it.
    always_comb begin
        if (op_r == ATD_OP_RAM_XOR) begin
            acc_o = ram_word;
        end else begin
            acc_o = acc_r;
        end
    end

    assign file_sel_o   = file_r;
    assign carry_flag_o = carry_r;
    assign skip_o       = 1'b0;
    assign done_o       = done_r;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_conv_issue;
        insn_valid_i && insn_i == OP_CONV_LOW;
    endsequence

    sequence s_ram_issue;
        insn_valid_i && insn_i[INSN_W-1:IMM_W] == OP_RAM_XOR_PFX;
    endsequence

    sequence s_wake_one_issue;
        insn_valid_i && insn_i == OP_WAKE_ONE;
    endsequence

    sequence s_wake_two_issue;
        insn_valid_i && insn_i == OP_WAKE_TWO;
    endsequence

    a_wake_one_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
        insn_valid_i && insn_i == OP_WAKE_ONE |=> acc_o == $past(wake_ctrl_one_i))
        else $error("Wake control one not loaded.");
    a_wake_two_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
        insn_valid_i && insn_i == OP_WAKE_TWO |=> acc_o == $past(wake_ctrl_two_i))
        else $error("Wake control two not loaded.");
    a_conv_high_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_conv_issue |=> acc_o[3:2] == $past(conv_result_i[1:0]))
        else $error("Conversion bits not placed high.");
    a_conv_low_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_conv_issue |=> acc_o[1:0] == CONV_LOW_FILL)
        else $error("Low accumulator bits not cleared.");
    a_ram_done_once: assert property (@(posedge clk_i) disable iff (!nrst_i)
        insn_valid_i && insn_i[9:4] == OP_RAM_XOR_PFX |=> done_o && !skip_o)
        else $error("RAM load not completed in one cycle.");
    a_ram_acc_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_ram_issue |=> acc_o == $past(u_ram.mem_r[data_pointer_i]))
        else $error("Accumulator does not show RAM word.");
    a_acc_hold_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_ram_issue ##1 (op_nxt == ATD_OP_NONE) |=> acc_o == $past(acc_o))
        else $error("Accumulator lost RAM word after idle cycle.");
    a_ram_carry_kept: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_ram_issue |=> carry_flag_o == $past(carry_flag_i))
        else $error("RAM load changed carry.");
    a_file_hold_other: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !(insn_valid_i && insn_i[INSN_W-1:IMM_W] == OP_RAM_XOR_PFX)
        |=> file_sel_o == $past(file_sel_o))
        else $error("File selector changed without RAM load.");
    a_wake_one_carry: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_wake_one_issue |=> carry_flag_o == $past(carry_flag_i) && done_o && !skip_o)
        else $error("Wake control one load changed carry or skipped.");
    a_wake_two_carry: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_wake_two_issue |=> carry_flag_o == $past(carry_flag_i) && done_o && !skip_o)
        else $error("Wake control two load changed carry or skipped.");
    a_file_xor: assert property (@(posedge clk_i) disable iff (!nrst_i)
        insn_valid_i && insn_i[9:4] == OP_RAM_XOR_PFX
        |=> file_sel_o == ($past(file_sel_o) ^ $past(insn_i[3:0])))
        else $error("File selector XOR wrong.");
    a_conv_carry_kept: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_conv_issue |=> carry_flag_o == $past(carry_flag_i) && done_o)
        else $error("Conversion load changed carry or took too long.");
endmodule

// *** common/atd_pkg.sv ***
// Package with opcodes, widths and field positions for the accumulator transfer decoder.
package atd_pkg;
    localparam int          INSN_W            = 10;
    localparam int          ACC_W             = 4;
    localparam int          FILE_W            = 4;
    localparam int          PTR_W             = 4;
    localparam int          CONV_W            = 10;
    localparam int          RAM_DEPTH         = 16;
    localparam int          IMM_W             = 4;
    localparam int          PFX_W             = 6;
    localparam logic [9:0]  OP_WAKE_ONE       = 10'h259;
    localparam logic [9:0]  OP_WAKE_TWO       = 10'h25A;
    // Opcode for the conversion-low transfer, a free slot next to the other loads.
    localparam logic [9:0]  OP_CONV_LOW       = 10'h24F;
    localparam logic [5:0]  OP_RAM_XOR_PFX    = 6'h2C;
    localparam logic [3:0]  ACC_RESET         = 4'h0;
    localparam logic [3:0]  FILE_RESET        = 4'h0;
    localparam logic [1:0]  CONV_LOW_FILL     = 2'h0;
    typedef enum logic [2:0] {
        ATD_OP_NONE,
        ATD_OP_WAKE_ONE,
        ATD_OP_WAKE_TWO,
        ATD_OP_CONV_LOW,
        ATD_OP_RAM_XOR
    } atd_op_e;
endpackage

// *** core/atd_ram.sv ***
// Small RAM word store with a registered read port.
`timescale 1ns/100ps
module atd_ram
    import atd_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              wr_en_i,
    input  wire logic [PTR_W-1:0]  wr_addr_i,
    input  wire logic [ACC_W-1:0]  wr_data_i,
    input  wire logic [PTR_W-1:0]  rd_addr_i,
    output logic      [ACC_W-1:0]  rd_data_o
);
    logic [ACC_W-1:0] mem_r [RAM_DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_data_o <= mem_r[rd_addr_i];
    end
endmodule

// *** tb/atd_decoder_test.sv ***
// Self-checking random testbench for the accumulator transfer decoder.
`timescale 1ns/100ps
module atd_decoder_test;
    import atd_pkg::*;
    logic              clk_i = 1'b0;
    logic              nrst_i = 1'b0;
    logic              insn_valid_i = 1'b0;
    logic [INSN_W-1:0] insn_i = '0;
    logic [ACC_W-1:0]  wake_ctrl_one_i = '0;
    logic [ACC_W-1:0]  wake_ctrl_two_i = '0;
    logic [CONV_W-1:0] conv_result_i = '0;
    logic [PTR_W-1:0]  data_pointer_i = '0;
    logic              ram_wr_en_i = 1'b0;
    logic [PTR_W-1:0]  ram_wr_addr_i = '0;
    logic [ACC_W-1:0]  ram_wr_data_i = '0;
    logic              carry_flag_i = 1'b0;
    logic [ACC_W-1:0]  acc_o;
    logic [FILE_W-1:0] file_sel_o;
    logic              carry_flag_o;
    logic              skip_o;
    logic              done_o;
    logic [ACC_W-1:0]  mem [RAM_DEPTH];
    logic [3:0]        e_acc, e_file, n_acc;
    logic              e_done, e_cy, n_done;
    int                fails = 0;
    int                check_count = 0;
    int                cycles = 0;
    int                k, op;
    logic [9:0]        w;
    logic [3:0]        k1, k2, dp, wa, wd;
    logic [9:0]        cv;
    logic              we, cy;
    atd_decoder dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .insn_valid_i(insn_valid_i),
        .insn_i(insn_i), .wake_ctrl_one_i(wake_ctrl_one_i), .wake_ctrl_two_i(wake_ctrl_two_i),
        .conv_result_i(conv_result_i), .data_pointer_i(data_pointer_i),
        .ram_wr_en_i(ram_wr_en_i), .ram_wr_addr_i(ram_wr_addr_i),
        .ram_wr_data_i(ram_wr_data_i), .carry_flag_i(carry_flag_i), .acc_o(acc_o),
        .file_sel_o(file_sel_o), .carry_flag_o(carry_flag_o), .skip_o(skip_o),
        .done_o(done_o));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [3:0] exp_acc(input int o, input logic [3:0] a,
        input logic [3:0] b, input logic [9:0] c, input logic [3:0] m, input logic [3:0] prev);
        case (o)
            0: return a;
            1: return b;
            2: return {c[1:0], 2'h0};
            3: return m;
            default: return prev;
        endcase
    endfunction
    function automatic logic known_op(input logic [9:0] x);
        return x == OP_WAKE_ONE || x == OP_WAKE_TWO || x == OP_CONV_LOW
            || x[9:4] == OP_RAM_XOR_PFX;
    endfunction
    task automatic give_verdict();
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Random instruction stream, checked at the falling edge half a cycle after each taking edge.
    initial begin
        void'($urandom(32'hbf56_88e8));
        {e_acc, e_file, e_done, e_cy} = '0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (k = 0; k < 1200; k++) begin
            @(posedge clk_i);
            op = (k < 16) ? 5 : int'($urandom % 6);
            w = 10'($urandom);
            if (op == 0) w = OP_WAKE_ONE;
            if (op == 1) w = OP_WAKE_TWO;
            if (op == 2) w = OP_CONV_LOW;
            if (op == 3) w = {OP_RAM_XOR_PFX, (k % 7 == 0) ? 4'h0 : (k % 7 == 1) ? 4'hf : w[3:0]};
            while (op == 4 && known_op(w)) w = 10'($urandom);
            k1 = 4'($urandom);
            k2 = 4'($urandom);
            cv = 10'($urandom);
            dp = 4'($urandom);
            cy = 1'($urandom);
            wa = (k < 16) ? 4'(k) : 4'($urandom);
            wd = 4'($urandom);
            we = (k < 16) || 1'($urandom);
            nrst_i <= (k != 600);
            insn_i <= w;
            insn_valid_i <= (op != 5);
            wake_ctrl_one_i <= k1;
            wake_ctrl_two_i <= k2;
            conv_result_i <= cv;
            data_pointer_i <= dp;
            carry_flag_i <= cy;
            ram_wr_en_i <= we;
            ram_wr_addr_i <= wa;
            ram_wr_data_i <= wd;
            n_done = op < 4;
            n_acc = exp_acc(op, k1, k2, cv, mem[dp], e_acc);
            @(negedge clk_i);
            if (we) mem[wa] = wd;
            chk(acc_o, e_acc);
            chk(file_sel_o, e_file);
            chk(carry_flag_o, e_cy);
            chk(done_o, e_done);
            chk(skip_o, 1'b0);
            if (op == 3) e_file = e_file ^ w[3:0];
            e_acc = n_acc;
            e_done = n_done;
            e_cy = cy;
            // A one-cycle reset in mid-run clears every output register.
            if (k == 600) {e_acc, e_file, e_done, e_cy} = '0;
        end
        give_verdict();
    end
endmodule
